// ### rtl/rpfs_top.sv
// run-time pin function settings with AXI4-Lite access to the packet buffers
// assumes the function sources are on clk; pin inputs arrive asynchronously
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`include "rpfs_consts.svh"
`default_nettype none
module rpfs_top (
	input wire logic clk, // 25 MHz clock
	input wire logic reset_n, // async reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [3:0] pinIn, // pin levels, bit 0 is pin_zero
	output logic [3:0] pinOut, // pin drive levels
	output logic [3:0] pinOe_n, // pin drive enables, low drives
	input wire logic suspendIndicator, // suspend state level
	input wire logic uartReceiveActivityLed, // rx activity led level
	input wire logic refClockOut, // divided reference clock
	input wire logic uartTransmitActivityLed, // tx activity led level
	input wire logic usbConfiguredIndicator, // configured level
	input wire logic i2cActivityLed, // i2c activity led level
	output logic [2:0] analogInputSelect, // analog input first..third routed
	output logic [1:0] dacOutputSelect, // dac output first, second routed
	output logic interruptDetectIn, // pin_one level for edge detector
	output logic interruptDetectEnable // pin_one given to edge detector
);

	// ****************************************
	// pin function decode
	// ****************************************
	// returns {oe_n, level} for one pin; undefined codes leave the pin undriven
	function automatic logic [1:0] pinDrive(input logic [1:0] idx, input logic [7:0] cfg,
			input logic [5:0] src);
		logic [1:0] d;
		d = 2'b10;
		case (cfg[2:0]) // see (R11)
			`RPFS_SEL_IO: begin
				if (!cfg[`RPFS_FIELD_DIR]) begin // see (R4)
					d = {1'b0, cfg[`RPFS_FIELD_LEVEL]}; // see (R5)
				end
			end
			`RPFS_SEL_DEDICATED: begin
				case (idx)
					2'd0: d = {1'b0, src[0]}; // see (R10)
					2'd1: d = {1'b0, src[2]}; // see (R1)
					2'd2: d = {1'b0, src[4]}; // see (R2)
					default: d = {1'b0, src[5]}; // see (R3)
				endcase
			end
			`RPFS_SEL_ALT0: begin
				if (idx == 2'd0) begin
					d = {1'b0, src[1]}; // see (R10)
				end
			end
			`RPFS_SEL_ALT1: begin
				if (idx == 2'd1) begin
					d = {1'b0, src[3]}; // see (R1)
				end
			end
			default: d = 2'b10;
		endcase
		return d;
	endfunction : pinDrive
	logic [7:0] pinCfg_reg [0:3];
	logic [7:0] pinCfg_next [0:3];
	logic [3:0] pinMeta_reg;
	logic [3:0] pinSync_reg;
	logic [5:0] fnSrc;
	logic [7:0] pinDriveVec;
	assign fnSrc = {i2cActivityLed, usbConfiguredIndicator, uartTransmitActivityLed,
		refClockOut, uartReceiveActivityLed, suspendIndicator};
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pinDriveVec[2*i +: 2] = pinDrive(2'(i), pinCfg_reg[i], fnSrc);
			pinOe_n[i] = pinDriveVec[2*i+1];
			pinOut[i] = pinDriveVec[2*i];
		end
		analogInputSelect[0] = (pinCfg_reg[1][2:0] == `RPFS_SEL_ALT0); // see (R1)
		analogInputSelect[1] = (pinCfg_reg[2][2:0] == `RPFS_SEL_ALT0); // see (R2)
		analogInputSelect[2] = (pinCfg_reg[3][2:0] == `RPFS_SEL_ALT0); // see (R3)
		dacOutputSelect[0] = (pinCfg_reg[2][2:0] == `RPFS_SEL_ALT1); // see (R2)
		dacOutputSelect[1] = (pinCfg_reg[3][2:0] == `RPFS_SEL_ALT1); // see (R3)
		interruptDetectEnable = (pinCfg_reg[1][2:0] == `RPFS_SEL_ALT2); // see (R1)
		interruptDetectIn = pinSync_reg[1] & interruptDetectEnable;
	end

	// ****************************************
	// command buffer and execution
	// ****************************************
	// only bytes 0 to 11 are kept; the rest of the packet has no effect
	logic [31:0] cmd_reg [0:2];
	logic [31:0] cmd_next [0:2];
	rpfs_pkg::rpfs_reply_t reply_reg, reply_next;
	logic done_reg, done_next;
	logic [7:0] awAddr_reg, awAddr_next;
	logic awHeld_reg, awHeld_next;
	logic [31:0] wData_reg, wData_next;
	logic [3:0] wStrb_reg, wStrb_next;
	logic wHeld_reg, wHeld_next;
	logic bValid_reg, bValid_next;
	logic [1:0] bResp_reg, bResp_next;
	logic rValid_reg, rValid_next;
	logic [31:0] rData_reg, rData_next;
	logic [1:0] rResp_reg, rResp_next;
	logic doWrite;
	logic exec;

	function automatic logic [7:0] replyByte(input logic [5:0] b, input rpfs_pkg::rpfs_reply_t k,
			input logic [31:0] pins);
		logic [7:0] v;
		v = 8'h00; // see (R6)
		if (b == 6'd0) begin
			case (k)
				rpfs_pkg::RPFS_REPLY_SET: v = `RPFS_CODE_SET;
				rpfs_pkg::RPFS_REPLY_GET: v = `RPFS_CODE_GET;
				default: v = 8'h00;
			endcase
		end else if (b == 6'd1) begin
			v = (k == rpfs_pkg::RPFS_REPLY_BAD) ? `RPFS_ACK_BAD : `RPFS_ACK_OK;
		end else if (k == rpfs_pkg::RPFS_REPLY_GET) begin
			if (b == 6'd2) begin
				v = `RPFS_CHIP_AREA_LEN;
			end else if (b == 6'd3) begin
				v = `RPFS_PIN_AREA_LEN;
			end else if (b >= `RPFS_REPLY_PIN_BYTE && b < `RPFS_REPLY_PIN_BYTE + 6'd4) begin
				v = pins[8*(b - `RPFS_REPLY_PIN_BYTE) +: 8];
			end
		end
		return v;
	endfunction : replyByte
	always_comb begin
		awAddr_next = awAddr_reg;
		awHeld_next = awHeld_reg;
		wData_next = wData_reg;
		wStrb_next = wStrb_reg;
		wHeld_next = wHeld_reg;
		bValid_next = bValid_reg;
		bResp_next = bResp_reg;
		cmd_next = cmd_reg;
		pinCfg_next = pinCfg_reg;
		reply_next = reply_reg;
		done_next = done_reg;
		exec = 1'b0;
		s_axi_awready = !awHeld_reg;
		s_axi_wready = !wHeld_reg;
		if (s_axi_awvalid && !awHeld_reg) begin
			awAddr_next = s_axi_awaddr;
			awHeld_next = 1'b1;
		end
		if (s_axi_wvalid && !wHeld_reg) begin
			wData_next = s_axi_wdata;
			wStrb_next = s_axi_wstrb;
			wHeld_next = 1'b1;
		end
		doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
		if (bValid_reg && s_axi_bready) begin
			bValid_next = 1'b0;
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
		end
		if (doWrite) begin
			bValid_next = 1'b1;
			bResp_next = `RPFS_RESP_OKAY;
			if (awAddr_reg >= `RPFS_ADDR_CMD_FIRST && awAddr_reg <= `RPFS_ADDR_CMD_LAST) begin
				if (awAddr_reg[7:2] < 6'(`RPFS_CMD_WORDS)) begin // see (R11)
					for (int k = 0; k < 4; k++) begin
						if (wStrb_reg[k]) begin
							cmd_next[awAddr_reg[3:2]][8*k +: 8] = wData_reg[8*k +: 8];
						end
					end
				end
			end else if (awAddr_reg == `RPFS_ADDR_CTRL) begin
				exec = wData_reg[`RPFS_CTRL_EXEC_BIT] && wStrb_reg[0];
				if (wStrb_reg[0]) begin
					done_next = 1'b0;
				end
			end else begin
				bResp_next = `RPFS_RESP_SLVERR;
			end
		end
		if (exec) begin
			done_next = 1'b1;
			if (cmd_reg[0][7:0] == `RPFS_CODE_SET) begin
				reply_next = rpfs_pkg::RPFS_REPLY_SET; // see (R6)
				if (cmd_reg[1][`RPFS_ALTER_BIT]) begin // see (R9)
					for (int i = 0; i < 4; i++) begin
						pinCfg_next[i] = cmd_reg[2][8*i +: 8];
					end
				end
			end else if (cmd_reg[0][7:0] == `RPFS_CODE_GET) begin // see (R7)
				reply_next = rpfs_pkg::RPFS_REPLY_GET;
			end else begin
				reply_next = rpfs_pkg::RPFS_REPLY_BAD;
			end
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	always_comb begin
		rValid_next = rValid_reg;
		rData_next = rData_reg;
		rResp_next = rResp_reg;
		s_axi_arready = !rValid_reg;
		if (rValid_reg && s_axi_rready) begin
			rValid_next = 1'b0;
		end
		if (s_axi_arvalid && !rValid_reg) begin
			rValid_next = 1'b1;
			rData_next = 32'h0000_0000;
			rResp_next = `RPFS_RESP_OKAY;
			if (s_axi_araddr >= `RPFS_ADDR_CMD_FIRST && s_axi_araddr <= `RPFS_ADDR_CMD_LAST) begin
				if (s_axi_araddr[7:2] < 6'(`RPFS_CMD_WORDS)) begin
					rData_next = cmd_reg[s_axi_araddr[3:2]];
				end
			end else if (s_axi_araddr >= `RPFS_ADDR_REPLY_FIRST &&
					s_axi_araddr <= `RPFS_ADDR_REPLY_LAST) begin
				for (int k = 0; k < 4; k++) begin
					rData_next[8*k +: 8] = replyByte({s_axi_araddr[5:2], 2'(k)}, reply_reg,
						{pinCfg_reg[3], pinCfg_reg[2], pinCfg_reg[1], pinCfg_reg[0]});
				end
			end else if (s_axi_araddr == `RPFS_ADDR_CTRL) begin
				rData_next = 32'h0000_0000;
			end else if (s_axi_araddr == `RPFS_ADDR_STATUS) begin
				rData_next[`RPFS_STATUS_DONE_BIT] = done_reg;
				rData_next[`RPFS_STATUS_KIND_LSB +: 2] = reply_reg;
				rData_next[`RPFS_STATUS_PIN_LSB +: 4] = pinSync_reg;
			end else begin
				rResp_next = `RPFS_RESP_SLVERR;
			end
		end
	end

	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata = rData_reg;
	assign s_axi_rresp = rResp_reg;

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 4; i++) begin
				pinCfg_reg[i] <= `RPFS_PIN_RESET;
			end
			for (int i = 0; i < 3; i++) begin
				cmd_reg[i] <= 32'h0000_0000;
			end
			pinMeta_reg <= 4'h0;
			pinSync_reg <= 4'h0;
			reply_reg <= rpfs_pkg::RPFS_REPLY_NONE;
			done_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			awHeld_reg <= 1'b0;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			wHeld_reg <= 1'b0;
			bValid_reg <= 1'b0;
			bResp_reg <= 2'h0;
			rValid_reg <= 1'b0;
			rData_reg <= 32'h0000_0000;
			rResp_reg <= 2'h0;
		end else begin
			pinCfg_reg <= pinCfg_next;
			cmd_reg <= cmd_next;
			pinMeta_reg <= pinIn;
			pinSync_reg <= pinMeta_reg;
			reply_reg <= reply_next;
			done_reg <= done_next;
			awAddr_reg <= awAddr_next;
			awHeld_reg <= awHeld_next;
			wData_reg <= wData_next;
			wStrb_reg <= wStrb_next;
			wHeld_reg <= wHeld_next;
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			rValid_reg <= rValid_next;
			rData_reg <= rData_next;
			rResp_reg <= rResp_next;
		end
	end
endmodule : rpfs_top
`default_nettype wire

// ### rtl/rpfs_consts.svh
// constants of the run-time pin function settings block
// assumes a 32-bit AXI4-Lite register bus and four two-way pins
//
// Functional notes
// (R1) pin_one codes: io, clock, analog, txled, irq
// (R2) pin_two codes: io, configured, analog, dac
// (R3) pin_three codes: io, i2c led, analog, dac
// (R4) bit 3 direction, only in io mode
// (R5) io output drives bit 4 level
// (R6) set reply: 0x60, 0x00, rest meaningless
// (R7) host reads settings with code 0x61
// (R8) host zero-fills read command bytes 1-63
// (R9) load pins only if byte 7 bit 7
// (R10) pin_zero codes: io, suspend, rx led
// (R11) ignore bits 7-5 and bytes 12-63
`ifndef RPFS_CONSTS_SVH
`define RPFS_CONSTS_SVH

`define RPFS_ADDR_CMD_FIRST 8'h00
`define RPFS_ADDR_CMD_LAST 8'h3C
`define RPFS_ADDR_REPLY_FIRST 8'h40
`define RPFS_ADDR_REPLY_LAST 8'h7C
`define RPFS_ADDR_CTRL 8'h80
`define RPFS_ADDR_STATUS 8'h84

`define RPFS_CTRL_EXEC_BIT 0
`define RPFS_STATUS_DONE_BIT 0
`define RPFS_STATUS_PIN_LSB 8
`define RPFS_STATUS_KIND_LSB 4

`define RPFS_CODE_SET 8'h60
`define RPFS_CODE_GET 8'h61
`define RPFS_ACK_OK 8'h00
`define RPFS_ACK_BAD 8'h01
`define RPFS_CHIP_AREA_LEN 8'h00
`define RPFS_PIN_AREA_LEN 8'h04
`define RPFS_REPLY_PIN_BYTE 6'h04

`define RPFS_CMD_WORDS 3
`define RPFS_ALTER_BIT 31
`define RPFS_FIELD_LEVEL 4
`define RPFS_FIELD_DIR 3
`define RPFS_PIN_RESET 8'h08

`define RPFS_SEL_IO 3'h0
`define RPFS_SEL_DEDICATED 3'h1
`define RPFS_SEL_ALT0 3'h2
`define RPFS_SEL_ALT1 3'h3
`define RPFS_SEL_ALT2 3'h4

`define RPFS_RESP_OKAY 2'h0
`define RPFS_RESP_SLVERR 2'h2

`endif

// ### rtl/rpfs_pkg.sv
// types of the run-time pin function settings block
// holds the reply kind encodings itself; rpfs_consts.svh holds the other numbers
`default_nettype none
package rpfs_pkg;
	typedef enum logic [1:0] {
		RPFS_REPLY_NONE = 2'b00,
		RPFS_REPLY_SET = 2'b01,
		RPFS_REPLY_GET = 2'b10,
		RPFS_REPLY_BAD = 2'b11
	} rpfs_reply_t;
endpackage : rpfs_pkg
`default_nettype wire

// ### tb/rpfs_pin_model.sv
// pin-side partner: board wires with pull-ups and free-running function sources
// assumes the block's pin ports, its clock and its reset
`default_nettype none
module rpfs_pin_model (
	input wire logic clk, // clock
	input wire logic reset_n, // reset, active low
	input wire logic [3:0] pinOut, // block drive levels
	input wire logic [3:0] pinOe_n, // block drive enables, low drives
	output logic [3:0] pinIn, // wire levels seen back
	output logic [5:0] srcLevels // function source levels
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] count_reg;
	logic [5:0] count_next;
	// released pins float high, never hold the last driven level
	assign pinIn = pinOut | pinOe_n;
	assign srcLevels = count_reg;
	// odd step so every source bit keeps moving
	always_comb begin
		count_next = count_reg + 6'h0B;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= 6'h15;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule : rpfs_pin_model
`default_nettype wire

// ### tb/rpfs_props.sv
// checker of the pin function settings block, bound to its top ports
// assumes one clock domain with an async active-low reset
`default_nettype none
module rpfs_checker (
	input wire logic clk, // clock
	input wire logic reset_n, // reset
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic [3:0] pinIn, // pin levels
	input wire logic [3:0] pinOe_n, // drive enables
	input wire logic [2:0] analogInputSelect, // analog routes
	input wire logic [1:0] dacOutputSelect, // dac routes
	input wire logic interruptDetectIn, // irq level
	input wire logic interruptDetectEnable // irq route
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence wrBoth;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rdTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_WR_ANSWER: assert property (wrBoth |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	AST_RD_ANSWER: assert property (rdTaken |=> s_axi_rvalid)
		else $error("read response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	// pin routes move only at the edge that answers a command write
	AST_CFG_AT_EXEC: assert property (
		$changed({pinOe_n, analogInputSelect, dacOutputSelect, interruptDetectEnable})
		|-> $rose(s_axi_bvalid))
		else $error("pin routing changed outside execute");
	// two flops lie between the pin and the edge detector level
	AST_IRQ_GATE: assert property (
		interruptDetectIn == (interruptDetectEnable && $past(pinIn[1], 2)))
		else $error("irq level not the gated synchronised pin");
	AST_IRQ_FLOAT: assert property (
		interruptDetectEnable |-> pinOe_n[1] && !analogInputSelect[0])
		else $error("irq pin driven or doubly routed");
	AST_ANA_FLOAT: assert property ((analogInputSelect & ~pinOe_n[3:1]) == 3'h0)
		else $error("analog pin driven");
	AST_DAC_FLOAT: assert property (
		(dacOutputSelect & (~pinOe_n[3:2] | analogInputSelect[2:1])) == 2'h0)
		else $error("dac pin driven or doubly routed");
endmodule : rpfs_checker
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench of the pin function settings block over AXI4-Lite
// assumes rpfs_top, rpfs_pin_model and rpfs_checker are compiled first
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, pinIn, pinOut, pinOe_n;
	logic [1:0] s_axi_bresp, s_axi_rresp, dacOutputSelect, r;
	logic [2:0] analogInputSelect;
	logic [5:0] srcLevels;
	logic suspendIndicator, uartReceiveActivityLed, refClockOut, uartTransmitActivityLed;
	logic usbConfiguredIndicator, i2cActivityLed, interruptDetectIn, interruptDetectEnable;
	logic [31:0] cfgs [5] = '{32'hE103_0210, 32'h0302_0401, 32'h0801_0302, 32'h0004_0107,
		32'h0C17_0503};
	int mismatches, comparisons, cycles;
	assign {suspendIndicator, uartReceiveActivityLed, refClockOut} = srcLevels[2:0];
	assign {uartTransmitActivityLed, usbConfiguredIndicator, i2cActivityLed} = srcLevels[5:3];
	rpfs_top DUT (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pinIn, .pinOut, .pinOe_n, .suspendIndicator, .uartReceiveActivityLed,
		.refClockOut, .uartTransmitActivityLed, .usbConfiguredIndicator, .i2cActivityLed,
		.analogInputSelect, .dacOutputSelect, .interruptDetectIn, .interruptDetectEnable);
	rpfs_pin_model pins (.clk, .reset_n, .pinOut, .pinOe_n, .pinIn, .srcLevels);
	// ****
	// shared tasks
	// ****
	task automatic test_done;
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
		logic awDone, wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				awDone = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wDone = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		// ready raised late on purpose so the response must stand
		do @(posedge clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge clk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axiWrite
	task automatic axiRead(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] resp);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge clk);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axiRead
	task automatic command(input logic [7:0] code, input logic [31:0] w1, input logic [31:0] w2);
		axiWrite(8'h00, {24'h0, code}, r);
		axiWrite(8'h04, w1, r);
		axiWrite(8'h08, w2, r);
		// reserved word dirty on a set, zero on a get as the host must send it
		axiWrite(8'h0C, (code == 8'h61) ? 32'h0000_0000 : 32'hFFFF_FFFF, r);
		axiWrite(8'h80, 32'h0000_0001, r);
		check({30'h0, r}, 32'h0000_0000);
	endtask : command
	// ****
	// scenarios
	// ****
	task automatic checkPins(input logic [31:0] cfg);
		logic [3:0] oe, lvl, ded;
		logic [2:0] c, ana;
		logic [1:0] dac;
		logic irq;
		#1;
		ded = {i2cActivityLed, usbConfiguredIndicator, refClockOut, suspendIndicator};
		ana = 3'h0;
		dac = 2'h0;
		irq = 1'b0;
		for (int p = 0; p < 4; p++) begin
			c = cfg[8*p +: 3];
			oe[p] = !((c == 3'h0 && !cfg[8*p+3]) || c == 3'h1 || (c == 3'h2 && p == 0)
				|| (c == 3'h3 && p == 1));
			lvl[p] = (c == 3'h0) ? cfg[8*p+4] : (c == 3'h1) ? ded[p]
				: (p == 0) ? uartReceiveActivityLed : uartTransmitActivityLed;
			if (p > 0) ana[p-1] = (c == 3'h2);
			if (p > 1) dac[p-2] = (c == 3'h3);
			if (p == 1) irq = (c == 3'h4);
		end
		check({28'h0, pinOe_n}, {28'h0, oe});
		check({28'h0, pinOut & ~oe}, {28'h0, lvl & ~oe});
		check({29'h0, analogInputSelect}, {29'h0, ana});
		check({30'h0, dacOutputSelect}, {30'h0, dac});
		check({31'h0, interruptDetectEnable}, {31'h0, irq});
	endtask : checkPins
	task automatic setPins(input logic alter, input logic [31:0] cfg);
		command(8'h60, {alter, 31'h7F00_0000}, cfg);
		axiRead(8'h40, d, r);
		check({16'h0, d[15:0]}, 32'h0000_0060);
		check({30'h0, r}, 32'h0000_0000);
	endtask : setPins
	task automatic getAndStray;
		command(8'h61, 32'h0, 32'h0);
		axiRead(8'h40, d, r);
		check(d, 32'h0400_0061);
		axiRead(8'h44, d, r);
		check(d, cfgs[4]);
		// done set, get reply kind, every released pin pulled high
		axiRead(8'h84, d, r);
		check(d, 32'h0000_0F21);
		axiWrite(8'h88, 32'h0, r);
		check({30'h0, r}, 32'h2);
		axiRead(8'h88, d, r);
		check({30'h0, r}, 32'h2);
		check(d, 32'h0);
	endtask : getAndStray
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			test_done();
		end
	end
	initial begin
		{reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		checkPins(32'h0808_0808);
		foreach (cfgs[i]) begin
			setPins(1'b1, cfgs[i]);
			checkPins(cfgs[i]);
		end
		setPins(1'b0, 32'h0000_0000);
		checkPins(cfgs[4]);
		getAndStray();
		test_done();
	end
endmodule : testbench
bind rpfs_top rpfs_checker chk (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pinIn, .pinOe_n, .analogInputSelect,
	.dacOutputSelect, .interruptDetectIn, .interruptDetectEnable);
`default_nettype wire
